// ==== logic/gip_port.sv ====
// Behaviour
// - bytes move on eight lines, bit zero least significant, bit seven most.
// - interface clear low returns all interface functions except remote and lockout to default.
// - bytes under attention low are commands, otherwise device data.
// - device pulls service request low to ask for service.
// - remote state only reachable while remote enable is held low.
// - end line low with data under attention high marks last byte.
// - end line low under attention low triggers parallel poll response.
// - data valid low only while a stable byte is driven.
// - acceptor holds not-ready low; source waits for its release.
// - acceptor holds not-accepted low until byte taken; source waits release.
// - full source and acceptor handshakes implemented.
// - listener, left when own talk address arrives.
// - talker with serial poll, left when own listen address arrives.
// - service request and parallel poll functions implemented.
// - remote and local switching, including return to local.
// - device clear commands pulse a clear output.
// - group execute trigger pulses a trigger output.
`include "gip_defs.svh"
module gip_port (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [4:0] my_addr_i,
	input wire logic [2:0] pp_line_i,
	input wire logic pp_sense_i,
	input wire logic pp_enable_i,
	input wire logic [7:0] bus_dio_n_i,
	output logic [7:0] bus_dio_n_o,
	output logic [7:0] bus_dio_oe_o,
	input wire logic bus_ifc_n_i,
	input wire logic bus_atn_n_i,
	input wire logic bus_ren_n_i,
	input wire logic bus_eoi_n_i,
	output logic bus_eoi_n_o,
	output logic bus_eoi_oe_o,
	output logic bus_srq_n_o,
	output logic bus_srq_oe_o,
	input wire logic bus_dav_n_i,
	output logic bus_dav_n_o,
	output logic bus_dav_oe_o,
	input wire logic bus_nrfd_n_i,
	output logic bus_nrfd_n_o,
	output logic bus_nrfd_oe_o,
	input wire logic bus_ndac_n_i,
	output logic bus_ndac_n_o,
	output logic bus_ndac_oe_o,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_last_i,
	output logic tx_ready_o,
	output logic [7:0] rx_data_o,
	output logic rx_last_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i,
	input wire logic srq_req_i,
	input wire logic [5:0] status_i,
	input wire logic local_req_i,
	output logic listen_o,
	output logic talk_o,
	output logic remote_o,
	output logic lockout_o,
	output logic clear_o,
	output logic trigger_o
);
	// two-stage synchronisers for the twelve data, clear, attention, remote enable and end bus inputs
	logic [11:0] sync1_q;
	logic [11:0] sync2_q;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q <= 12'hfff;
			sync2_q <= 12'hfff;
		end else begin
			sync1_q <= {bus_dio_n_i, bus_ifc_n_i, bus_atn_n_i, bus_ren_n_i, bus_eoi_n_i};
			sync2_q <= sync1_q;
		end
	end
	// true-level views of the synchronised lines; dio inverted so bit 0 is lsb of the byte
	wire [7:0] dio = ~sync2_q[11:4];
	wire ifc = ~sync2_q[3];
	wire atn = ~sync2_q[2];
	wire ren = ~sync2_q[1];
	wire eoi = ~sync2_q[0];
	// handshake inputs, synchronised separately to keep widths plain
	logic [2:0] hs1_q;
	logic [2:0] hs2_q;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hs1_q <= 3'h7;
			hs2_q <= 3'h7;
		end else begin
			hs1_q <= {bus_dav_n_i, bus_nrfd_n_i, bus_ndac_n_i};
			hs2_q <= hs1_q;
		end
	end
	wire dav = ~hs2_q[2];
	wire nrfd = ~hs2_q[1];
	wire ndac = ~hs2_q[0];

	// acceptor handshake state
	gip_pkg::gip_acc_e acc_q, acc_d;
	logic [7:0] rx_data_q;
	logic rx_last_q, rx_valid_q;
	logic listen_q, talk_q, remote_q, lockout_q, spe_q, clear_q, trigger_q;
	logic srq_q, rqs_q;
	// commands are accepted by every device; data only when listening
	wire acc_on = atn | listen_q;
	wire buf_free = ~rx_valid_q | rx_ready_i;
	wire take = (acc_q == gip_pkg::ACC_READY) & dav & acc_on;
	wire [7:0] cmd = dio & `GIP_CMD_MASK;
	wire is_cmd = take & atn;
	wire own_listen = is_cmd & (cmd[6:5] == `GIP_GRP_LISTEN) & (cmd[4:0] == my_addr_i);
	wire own_talk = is_cmd & (cmd[6:5] == `GIP_GRP_TALK) & (cmd[4:0] == my_addr_i);
	wire c_unl = is_cmd & (cmd == `GIP_CMD_UNL);
	wire c_unt = is_cmd & (cmd == `GIP_CMD_UNT);
	wire c_dcl = is_cmd & ((cmd == `GIP_CMD_DCL) | ((cmd == `GIP_CMD_SDC) & listen_q));
	wire c_get = is_cmd & (cmd == `GIP_CMD_GET) & listen_q;
	wire c_gtl = is_cmd & (cmd == `GIP_CMD_GTL) & listen_q;
	wire c_llo = is_cmd & (cmd == `GIP_CMD_LLO);
	wire c_spe = is_cmd & (cmd == `GIP_CMD_SPE);
	wire c_spd = is_cmd & (cmd == `GIP_CMD_SPD);
	wire data_take = take & ~atn & buf_free;

	// acceptor: ready when free, not-accepted released once byte taken
	always_comb begin
		acc_d = acc_q;
		case (acc_q)
			gip_pkg::ACC_READY: if (take && (atn || buf_free)) acc_d = gip_pkg::ACC_TAKE;
			gip_pkg::ACC_TAKE: acc_d = gip_pkg::ACC_WAIT_DROP;
			gip_pkg::ACC_WAIT_DROP: if (!dav) acc_d = gip_pkg::ACC_READY;
			default: acc_d = gip_pkg::ACC_READY;
		endcase
	end
	// hold not-ready low unless idle with room or under attention; hold not-accepted low until taken
	wire acc_rfd = acc_on & (acc_q == gip_pkg::ACC_READY) & (atn | buf_free) & ~dav;
	wire acc_dac = acc_on & ((acc_q == gip_pkg::ACC_TAKE) | (acc_q == gip_pkg::ACC_WAIT_DROP));
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) acc_q <= gip_pkg::ACC_READY;
		else if (ifc) acc_q <= gip_pkg::ACC_READY;
		else acc_q <= acc_d;
	end
	// received data byte with its end mark
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_data_q <= 8'h00;
			rx_last_q <= 1'b0;
			rx_valid_q <= 1'b0;
		end else if (data_take && (acc_q == gip_pkg::ACC_READY)) begin
			rx_data_q <= dio;
			rx_last_q <= eoi;
			rx_valid_q <= 1'b1;
		end else if (rx_ready_i) begin
			rx_valid_q <= 1'b0;
		end
	end

	// addressing, remote/local, clear and trigger
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			listen_q <= 1'b0;
			talk_q <= 1'b0;
			spe_q <= 1'b0;
		end else if (ifc) begin
			listen_q <= 1'b0;
			talk_q <= 1'b0;
			spe_q <= 1'b0;
		end else begin
			if (own_listen) listen_q <= 1'b1;
			else if (c_unl || own_talk) listen_q <= 1'b0;
			if (own_talk) talk_q <= 1'b1;
			else if (c_unt || own_listen || (is_cmd && cmd[6:5] == `GIP_GRP_TALK)) talk_q <= 1'b0;
			if (c_spe) spe_q <= 1'b1;
			else if (c_spd) spe_q <= 1'b0;
		end
	end
	// remote only while remote enable held; local by front panel unless locked out
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			remote_q <= 1'b0;
			lockout_q <= 1'b0;
		end else if (!ren) begin
			remote_q <= 1'b0;
			lockout_q <= 1'b0;
		end else begin
			if (own_listen) remote_q <= 1'b1;
			else if (c_gtl || (local_req_i && !lockout_q)) remote_q <= 1'b0;
			if (c_llo) lockout_q <= 1'b1;
		end
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clear_q <= 1'b0;
			trigger_q <= 1'b0;
		end else begin
			clear_q <= c_dcl;
			trigger_q <= c_get;
		end
	end

	// service request: rqs cleared once status byte is sent in serial poll
	gip_pkg::gip_src_e src_q, src_d;
	wire src_send_done;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) rqs_q <= 1'b0;
		else if (!srq_req_i || ifc) rqs_q <= 1'b0;
		else if (!rqs_q && !srq_q) rqs_q <= 1'b1;
		else if (src_send_done && spe_q) rqs_q <= 1'b0;
	end
	// latch so a new request needs srq_req_i to drop first
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) srq_q <= 1'b0;
		else if (!srq_req_i) srq_q <= 1'b0;
		else if (rqs_q) srq_q <= 1'b1;
	end

	// source handshake; in serial poll the status byte replaces user data
	logic [7:0] tx_q;
	logic tx_last_q, tx_ready_q;
	wire src_act = talk_q & ~atn;
	wire [7:0] stb = {status_i[5], rqs_q, status_i};
	assign src_send_done = (src_q == gip_pkg::SRC_WAIT_DAC) & ~ndac & spe_q;
	always_comb begin
		src_d = src_q;
		case (src_q)
			gip_pkg::SRC_IDLE: if (src_act && (spe_q || tx_valid_i)) src_d = gip_pkg::SRC_WAIT_RFD;
			gip_pkg::SRC_WAIT_RFD: if (!nrfd) src_d = gip_pkg::SRC_DAV;
			gip_pkg::SRC_DAV: src_d = gip_pkg::SRC_WAIT_DAC;
			gip_pkg::SRC_WAIT_DAC: if (!ndac) src_d = gip_pkg::SRC_IDLE;
			default: src_d = gip_pkg::SRC_IDLE;
		endcase
		if (!src_act) src_d = gip_pkg::SRC_IDLE;
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src_q <= gip_pkg::SRC_IDLE;
			tx_q <= 8'h00;
			tx_last_q <= 1'b0;
			tx_ready_q <= 1'b0;
		end else if (ifc) begin
			src_q <= gip_pkg::SRC_IDLE;
			tx_ready_q <= 1'b0;
		end else begin
			src_q <= src_d;
			tx_ready_q <= (src_q == gip_pkg::SRC_IDLE) & src_act & ~spe_q & tx_valid_i & ~tx_ready_q;
			if (src_q == gip_pkg::SRC_IDLE && src_d == gip_pkg::SRC_WAIT_RFD) begin
				tx_q <= spe_q ? stb : tx_data_i;
				tx_last_q <= ~spe_q & tx_last_i;
			end
		end
	end

	// parallel poll: respond on assigned line while attention and end are low
	wire ppr = atn & eoi & pp_enable_i & ~ifc;
	wire pp_bit = (pp_sense_i == rqs_q);
	wire [7:0] pp_dio = {7'h00, pp_bit} << pp_line_i;
	wire drive_data = (src_q != gip_pkg::SRC_IDLE) & src_act;
	wire dav_on = (src_q == gip_pkg::SRC_DAV) | (src_q == gip_pkg::SRC_WAIT_DAC);
	// registered open-drain outputs: only ever pulled low or released
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_dio_oe_o <= 8'h00;
			bus_eoi_oe_o <= 1'b0;
			bus_srq_oe_o <= 1'b0;
			bus_dav_oe_o <= 1'b0;
			bus_nrfd_oe_o <= 1'b0;
			bus_ndac_oe_o <= 1'b0;
		end else begin
			bus_dio_oe_o <= ppr ? pp_dio : (drive_data ? tx_q : 8'h00);
			bus_eoi_oe_o <= drive_data & tx_last_q & ~ppr;
			bus_srq_oe_o <= rqs_q;
			bus_dav_oe_o <= dav_on & src_act;
			bus_nrfd_oe_o <= acc_on & ~acc_rfd & ~ifc;
			// not-accepted is pulled low only while idle; released from the take until data valid drops
			bus_ndac_oe_o <= acc_on & ~acc_dac & ~ifc;
		end
	end
	// low level always; a line is driven only through its enable
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_dio_n_o <= 8'h00;
			bus_eoi_n_o <= 1'b0;
			bus_srq_n_o <= 1'b0;
			bus_dav_n_o <= 1'b0;
			bus_nrfd_n_o <= 1'b0;
			bus_ndac_n_o <= 1'b0;
		end else begin
			bus_dio_n_o <= 8'h00;
			bus_eoi_n_o <= 1'b0;
			bus_srq_n_o <= 1'b0;
			bus_dav_n_o <= 1'b0;
			bus_nrfd_n_o <= 1'b0;
			bus_ndac_n_o <= 1'b0;
		end
	end
	assign tx_ready_o = tx_ready_q;
	assign rx_data_o = rx_data_q;
	assign rx_last_o = rx_last_q;
	assign rx_valid_o = rx_valid_q;
	assign listen_o = listen_q;
	assign talk_o = talk_q;
	assign remote_o = remote_q;
	assign lockout_o = lockout_q;
	assign clear_o = clear_q;
	assign trigger_o = trigger_q;

	// checks
	property p_ifc_clears;
		@(posedge ref_clk_i) disable iff (!rst_n_i) ifc |=> !listen_q && !talk_q;
	endproperty
	a_ifc_clears: assert property (p_ifc_clears) else $error("interface clear left addressing");
	property p_remote_needs_ren;
		@(posedge ref_clk_i) disable iff (!rst_n_i) !ren |=> !remote_q;
	endproperty
	a_remote_needs_ren: assert property (p_remote_needs_ren) else $error("remote without enable");
	property p_srq;
		@(posedge ref_clk_i) disable iff (!rst_n_i) rqs_q |=> bus_srq_oe_o;
	endproperty
	a_srq: assert property (p_srq) else $error("service request not driven");
	property p_dav_rfd;
		@(posedge ref_clk_i) disable iff (!rst_n_i) (src_q == gip_pkg::SRC_WAIT_RFD && nrfd) |=> src_q != gip_pkg::SRC_DAV;
	endproperty
	a_dav_rfd: assert property (p_dav_rfd) else $error("data valid while not ready");
	property p_hold_dac;
		@(posedge ref_clk_i) disable iff (!rst_n_i) (src_q == gip_pkg::SRC_WAIT_DAC && ndac && src_act && !ifc) |=> src_q == gip_pkg::SRC_WAIT_DAC;
	endproperty
	a_hold_dac: assert property (p_hold_dac) else $error("source left before accept");
	property p_talk_off;
		@(posedge ref_clk_i) disable iff (!rst_n_i) own_listen && !ifc |=> !talk_q;
	endproperty
	a_talk_off: assert property (p_talk_off) else $error("talker kept after own listen address");
	property p_listen_off;
		@(posedge ref_clk_i) disable iff (!rst_n_i) own_talk && !ifc |=> !listen_q;
	endproperty
	a_listen_off: assert property (p_listen_off) else $error("listener kept after own talk address");
	property p_trig;
		@(posedge ref_clk_i) disable iff (!rst_n_i) c_get |=> trigger_o ##1 !trigger_o || c_get;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger pulse wrong");
	property p_clr;
		@(posedge ref_clk_i) disable iff (!rst_n_i) c_dcl |=> clear_o;
	endproperty
	a_clr: assert property (p_clr) else $error("clear pulse missing");
	property p_pp;
		@(posedge ref_clk_i) disable iff (!rst_n_i) ppr |=> bus_dio_oe_o == $past(pp_dio);
	endproperty
	a_pp: assert property (p_pp) else $error("parallel poll response wrong");
	property p_ndac_release;
		@(posedge ref_clk_i) disable iff (!rst_n_i) acc_q == gip_pkg::ACC_TAKE |=> !bus_ndac_oe_o;
	endproperty
	a_ndac_release: assert property (p_ndac_release) else $error("not-accepted held after take");
	c_listen: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) own_listen);
	c_talk_byte: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) src_q == gip_pkg::SRC_DAV);
	c_rx_last: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) rx_valid_q && rx_last_q);
	c_spoll: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) src_send_done);
endmodule // gip_port

// ==== logic/gip_defs.svh ====
`ifndef GIP_DEFS_SVH
`define GIP_DEFS_SVH
// interface command bytes, sent with attention low
`define GIP_CMD_MASK 8'h7f
`define GIP_CMD_DCL 8'h14
`define GIP_CMD_SDC 8'h04
`define GIP_CMD_GET 8'h08
`define GIP_CMD_GTL 8'h01
`define GIP_CMD_LLO 8'h11
`define GIP_CMD_SPE 8'h18
`define GIP_CMD_SPD 8'h19
`define GIP_CMD_UNL 8'h3f
`define GIP_CMD_UNT 8'h5f
// address groups: bits 6:5 select listen or talk group
`define GIP_GRP_LISTEN 2'h1
`define GIP_GRP_TALK 2'h2
// serial poll status byte: service request bit position
`define GIP_RQS_BIT 6
`endif

// ==== logic/gip_pkg.sv ====
package gip_pkg;
	typedef enum logic [1:0] {SRC_IDLE, SRC_WAIT_RFD, SRC_DAV, SRC_WAIT_DAC} gip_src_e;
	typedef enum logic [1:0] {ACC_READY, ACC_TAKE, ACC_WAIT_DROP} gip_acc_e;
endpackage

// ==== testbench/gip_ctl_model.sv ====
// controller model: a drive bit high pulls its line low, released lines float high on the pull-ups
module gip_ctl_model (
	input wire logic ref_clk_i,
	input wire logic [7:0] dio_n_i,
	input wire logic eoi_n_i,
	input wire logic dav_n_i,
	input wire logic nrfd_n_i,
	input wire logic ndac_n_i,
	output logic [7:0] dio_o,
	output logic atn_o,
	output logic eoi_o,
	output logic dav_o,
	output logic nrfd_o,
	output logic ndac_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {dio_o, atn_o, eoi_o, dav_o, nrfd_o, ndac_o} = 13'h0000;
	// source one byte; attention picks command or data, last marks the final data byte
	task automatic send(input logic atn, input logic [7:0] b, input logic last);
		@(posedge ref_clk_i);
		atn_o <= atn;
		dio_o <= b;
		eoi_o <= last & ~atn;
		repeat (4) @(posedge ref_clk_i); // lets the listener's synchroniser see attention first
		while (nrfd_n_i !== 1'b1) @(posedge ref_clk_i);
		dav_o <= 1'b1;
		@(posedge ref_clk_i);
		while (ndac_n_i !== 1'b1) @(posedge ref_clk_i);
		dav_o <= 1'b0;
		dio_o <= 8'h00;
		eoi_o <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	// accept one byte; not-ready stays low for stall cycles, which must be at least one
	task automatic recv(input int stall, output logic [7:0] b, output logic last);
		@(posedge ref_clk_i);
		atn_o <= 1'b0;
		nrfd_o <= 1'b1;
		ndac_o <= 1'b1;
		repeat (stall) @(posedge ref_clk_i);
		nrfd_o <= 1'b0;
		while (dav_n_i !== 1'b0) @(posedge ref_clk_i);
		b = ~dio_n_i;
		last = ~eoi_n_i;
		nrfd_o <= 1'b1;
		ndac_o <= 1'b0;
		@(posedge ref_clk_i);
		while (dav_n_i !== 1'b1) @(posedge ref_clk_i);
		nrfd_o <= 1'b0;
	endtask
	// parallel poll: attention and end line low together, then read the data lines
	task automatic ppoll(output logic [7:0] resp);
		@(posedge ref_clk_i);
		atn_o <= 1'b1;
		eoi_o <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		resp = ~dio_n_i;
		atn_o <= 1'b0;
		eoi_o <= 1'b0;
	endtask
endmodule // gip_ctl_model

// ==== testbench/test_gip_port.sv ====
`include "gip_defs.svh"
module test_gip_port;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MY_LISTEN = 8'h25; // listen group, address 5
	localparam logic [7:0] MY_TALK = 8'h45; // talk group, address 5
	logic ref_clk_i = 1'b0, rst_n_i = 1'b0, bus_ifc_n_i = 1'b1, bus_ren_n_i = 1'b1;
	logic tx_valid_i = 1'b0, tx_last_i = 1'b0, rx_ready_i = 1'b0, srq_req_i = 1'b0, local_req_i = 1'b0;
	logic pp_enable_i = 1'b0, saw_clr = 1'b0, saw_trg = 1'b0, got_last;
	logic [7:0] tx_data_i = 8'h00, bus_dio_n_i, bus_dio_n_o, bus_dio_oe_o, c_dio, rx_data_o, got;
	logic bus_eoi_n_i, bus_eoi_n_o, bus_eoi_oe_o, bus_srq_n_o, bus_srq_oe_o, bus_dav_n_i, bus_dav_n_o, bus_dav_oe_o;
	logic bus_nrfd_n_i, bus_nrfd_n_o, bus_nrfd_oe_o, bus_ndac_n_i, bus_ndac_n_o, bus_ndac_oe_o, bus_atn_n_i;
	logic tx_ready_o, rx_last_o, rx_valid_o, listen_o, talk_o, remote_o, lockout_o, clear_o, trigger_o;
	logic c_atn, c_eoi, c_dav, c_nrfd, c_ndac;
	logic [7:0] cmds [3] = '{`GIP_CMD_DCL, `GIP_CMD_SDC, `GIP_CMD_GET};
	int n_fail = 0, n_tests = 0, cyc = 0;
	always #12.5 ref_clk_i = ~ref_clk_i;
	// wired-low bus: any party pulling a line low wins
	assign bus_dio_n_i = ~c_dio & (~bus_dio_oe_o | bus_dio_n_o);
	assign bus_eoi_n_i = ~c_eoi & (~bus_eoi_oe_o | bus_eoi_n_o);
	assign bus_dav_n_i = ~c_dav & (~bus_dav_oe_o | bus_dav_n_o);
	assign bus_nrfd_n_i = ~c_nrfd & (~bus_nrfd_oe_o | bus_nrfd_n_o);
	assign bus_ndac_n_i = ~c_ndac & (~bus_ndac_oe_o | bus_ndac_n_o);
	assign bus_atn_n_i = ~c_atn;
	gip_port gip_port_inst (.ref_clk_i, .rst_n_i, .my_addr_i(5'h05), .pp_line_i(3'h3), .pp_sense_i(1'b1),
		.pp_enable_i, .bus_dio_n_i, .bus_dio_n_o, .bus_dio_oe_o, .bus_ifc_n_i, .bus_atn_n_i, .bus_ren_n_i,
		.bus_eoi_n_i, .bus_eoi_n_o, .bus_eoi_oe_o, .bus_srq_n_o, .bus_srq_oe_o, .bus_dav_n_i, .bus_dav_n_o,
		.bus_dav_oe_o, .bus_nrfd_n_i, .bus_nrfd_n_o, .bus_nrfd_oe_o, .bus_ndac_n_i, .bus_ndac_n_o, .bus_ndac_oe_o,
		.tx_valid_i, .tx_data_i, .tx_last_i, .tx_ready_o, .rx_data_o, .rx_last_o, .rx_valid_o, .rx_ready_i,
		.srq_req_i, .status_i(6'h15), .local_req_i, .listen_o, .talk_o, .remote_o, .lockout_o, .clear_o,
		.trigger_o);
	gip_ctl_model ctl (.ref_clk_i(ref_clk_i), .dio_n_i(bus_dio_n_i), .eoi_n_i(bus_eoi_n_i), .dav_n_i(bus_dav_n_i),
		.nrfd_n_i(bus_nrfd_n_i), .ndac_n_i(bus_ndac_n_i), .dio_o(c_dio), .atn_o(c_atn), .eoi_o(c_eoi),
		.dav_o(c_dav), .nrfd_o(c_nrfd), .ndac_o(c_ndac));
	task automatic finish_test;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// pulses are one cycle wide, so catch them in sticky flags; the cycle ceiling cuts a hang
	always @(posedge ref_clk_i) begin
		if (clear_o === 1'b1) saw_clr <= 1'b1;
		if (trigger_o === 1'b1) saw_trg <= 1'b1;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			finish_test;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// received byte must wait for the user, then leave once taken
	task automatic take_rx(input logic [7:0] d, input logic l);
		check(8'(rx_valid_o), 8'h01);
		check(rx_data_o, d);
		check(8'(rx_last_o), 8'(l));
		rx_ready_i <= 1'b1;
		tick(1);
		rx_ready_i <= 1'b0;
		tick(2);
		check(8'(rx_valid_o), 8'h00);
	endtask
	task automatic t_listen;
		ctl.send(1'b1, MY_LISTEN, 1'b0);
		tick(2);
		check(8'(listen_o), 8'h01);
		ctl.send(1'b0, 8'h81, 1'b0);
		take_rx(8'h81, 1'b0);
		ctl.send(1'b0, 8'h3c, 1'b1);
		take_rx(8'h3c, 1'b1);
	endtask
	task automatic t_cmds;
		for (int i = 0; i < 3; i++) begin
			saw_clr <= 1'b0;
			saw_trg <= 1'b0;
			ctl.send(1'b1, cmds[i], 1'b0);
			tick(4);
			check(8'(saw_clr), 8'(i < 2));
			check(8'(saw_trg), 8'(i == 2));
		end
	endtask
	task automatic t_remote;
		ctl.send(1'b1, MY_LISTEN, 1'b0);
		tick(4);
		check(8'(remote_o), 8'h00);
		bus_ren_n_i <= 1'b0;
		ctl.send(1'b1, MY_LISTEN, 1'b0);
		tick(4);
		check(8'(remote_o), 8'h01);
		local_req_i <= 1'b1;
		tick(6);
		check(8'(remote_o), 8'h00);
		local_req_i <= 1'b0;
		// lockout blocks the front panel; only go-to-local or remote enable released ends remote
		ctl.send(1'b1, `GIP_CMD_LLO, 1'b0);
		ctl.send(1'b1, MY_LISTEN, 1'b0);
		local_req_i <= 1'b1;
		tick(6);
		check(8'({lockout_o, remote_o}), 8'h03);
		ctl.send(1'b1, `GIP_CMD_GTL, 1'b0);
		tick(2);
		check(8'(remote_o), 8'h00);
		local_req_i <= 1'b0;
		bus_ren_n_i <= 1'b1;
		tick(4);
		check(8'(lockout_o), 8'h00);
	endtask
	// talker waits while the acceptor holds not-ready low
	task automatic t_talk;
		ctl.send(1'b1, MY_TALK, 1'b0);
		tick(4);
		check(8'({talk_o, listen_o}), 8'h02);
		tx_data_i <= 8'hc3;
		tx_last_i <= 1'b1;
		tx_valid_i <= 1'b1;
		fork
			ctl.recv(14, got, got_last);
			begin
				do @(posedge ref_clk_i); while (tx_ready_o !== 1'b1);
				tx_valid_i <= 1'b0;
				repeat (8) begin
					tick(1);
					check(8'(bus_dav_oe_o), 8'h00);
				end
			end
		join
		check(got, 8'hc3);
		check(8'(got_last), 8'h01);
		ctl.send(1'b1, MY_LISTEN, 1'b0);
		tick(4);
		check(8'({talk_o, listen_o}), 8'h01);
	endtask
	task automatic t_poll;
		srq_req_i <= 1'b1;
		pp_enable_i <= 1'b1;
		tick(4);
		check(8'(bus_srq_oe_o), 8'h01);
		ctl.ppoll(got);
		check(got, 8'h08);
		ctl.send(1'b1, `GIP_CMD_SPE, 1'b0);
		ctl.send(1'b1, MY_TALK, 1'b0);
		ctl.recv(1, got, got_last);
		check(got, 8'h55);
		tick(2);
		check(8'(bus_srq_oe_o), 8'h00);
		srq_req_i <= 1'b0;
		ctl.send(1'b1, `GIP_CMD_SPD, 1'b0);
		tick(4);
		check(8'(bus_srq_oe_o), 8'h00);
	endtask
	// unaddress commands first, then interface clear drops a fresh listen address
	task automatic t_ifc;
		ctl.send(1'b1, MY_TALK, 1'b0);
		ctl.send(1'b1, `GIP_CMD_UNT, 1'b0);
		tick(2);
		check(8'({talk_o, listen_o}), 8'h00);
		ctl.send(1'b1, MY_LISTEN, 1'b0);
		ctl.send(1'b1, `GIP_CMD_UNL, 1'b0);
		tick(2);
		check(8'({talk_o, listen_o}), 8'h00);
		ctl.send(1'b1, MY_LISTEN, 1'b0);
		bus_ifc_n_i <= 1'b0;
		tick(4);
		bus_ifc_n_i <= 1'b1;
		tick(4);
		check(8'({talk_o, listen_o}), 8'h00);
	endtask
	initial begin
		tick(10);
		rst_n_i <= 1'b1;
		tick(3);
		t_listen;
		t_cmds;
		t_remote;
		t_talk;
		t_poll;
		t_ifc;
		finish_test;
	end
endmodule // test_gip_port
